// >>> cmpdb_pkg.sv
// constants, field layouts and state types of the comparator event and debounce logic
// assumes one system clock; register port, raw comparator outputs and timer overflow pulses
// Contract
// - no timer sampling: sample every clock
// - debounce at 00B: wait two overflows, resample
// - flag set only if resample matches
// - debounced flag one to two periods later
// - timer sampling: edge after 4 stable samples
// - timer sampling plus debounce: two overflows after
// - timer1 sampling: interrupt on second later overflow
// - connect bit one connects analog inputs
// - flag set on mode match while enabled
// - interrupt enable bit 6 gates request
// - disable forces output low, blocks events
// - enabled: shared comparator pins lose digital input; here only the selected positive channel pin of each enabled comparator
// - codes 010, 011, 110 are debounced modes
// - sample every clock or on timer overflow
package cmpdb_pkg;

    localparam int          NUM_CMP  = 2;
    localparam int          NUM_PINS = 4;
    localparam int          DB_TIMER = 1;

    localparam logic [7:0]  OFS_CMP_A = 8'ha3;
    localparam logic [7:0]  OFS_CMP_B = 8'hab;
    localparam logic [7:0]  OFS_CFG   = 8'ha1;
    localparam logic [7:0]  OFS_IE    = 8'ha8;
    localparam logic [7:0]  OFS_ISTS  = 8'hb0;
    localparam logic [7:0]  OFS_IMASK = 8'hb1;
    localparam logic [7:0]  CMP_OFS [NUM_CMP] = '{OFS_CMP_A, OFS_CMP_B};

    localparam logic [7:0]  RST_CMP_A = 8'h00;
    localparam logic [7:0]  RST_CMP_B = 8'hc0;
    localparam logic [7:0]  CMP_RST [NUM_CMP] = '{RST_CMP_A, RST_CMP_B};

    // control/status field positions
    localparam int          CHAN_LSB = 6;
    localparam int          CON_BIT  = 5;
    localparam int          FLAG_BIT = 4;
    localparam int          EN_BIT   = 3;
    localparam int          IE_CMP_BIT = 6;
    localparam int          CFG_RAW_LSB = 6;

    localparam logic [1:0]  SEL_SYSCLK     = 2'h0;
    localparam logic [2:0]  STABLE_SAMPLES = 3'h4;
    localparam logic [1:0]  DB_OVF         = 2'h2;

    typedef enum logic [1:0]
    {
        CMPDB_DB_IDLE = 2'b01,
        CMPDB_DB_WAIT = 2'b10
    } cmpdb_db_t;

    typedef struct packed
    {
        logic       lvl;
        logic       pol;
        logic       rise;
        logic       fall;
        logic       db;
    } cmpdb_mode_t;

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic       smp;
        logic       acc;
        logic [2:0] cnt;
        cmpdb_db_t  db;
        logic [1:0] dbcnt;
        logic       expv;
    } cmpdb_cmp_t;

    typedef struct packed
    {
        cmpdb_cmp_t [NUM_CMP-1:0]        cmp;
        logic [NUM_CMP-1:0]              sy1;
        logic [NUM_CMP-1:0]              sy2;
        logic [1:0]                      compare_sample_clock_select;
        logic [7:0]                      ie;
        logic [NUM_CMP-1:0]              ists;
        logic [NUM_CMP-1:0]              imask;
        logic                            irq;
        logic                            req;
        logic [NUM_CMP-1:0]              con;
        logic [NUM_CMP-1:0][1:0]         chan;
        logic [NUM_PINS-1:0]             dig_dis;
        logic [7:0]                      rdata;
    } cmpdb_state_t;

    function automatic cmpdb_mode_t cmpdb_decode(input logic [2:0] code);
        cmpdb_mode_t m;
        m = '0;
        unique case (code)
            3'h0: m.lvl = 1'b1;
            3'h1: m.rise = 1'b1;
            3'h2: m = '{lvl: 1'b0, pol: 1'b0, rise: 1'b1, fall: 1'b1, db: 1'b1};
            3'h3: m = '{lvl: 1'b0, pol: 1'b0, rise: 1'b1, fall: 1'b0, db: 1'b1};
            3'h4: m.fall = 1'b1;
            3'h5: m = '{lvl: 1'b0, pol: 1'b0, rise: 1'b1, fall: 1'b1, db: 1'b0};
            3'h6: m = '{lvl: 1'b0, pol: 1'b0, rise: 1'b0, fall: 1'b1, db: 1'b1};
            3'h7: m = '{lvl: 1'b1, pol: 1'b1, rise: 1'b0, fall: 1'b0, db: 1'b0};
        endcase
        return m;
    endfunction

endpackage

// >>> cmpdb_top.sv
// event, edge qualification and debounce logic behind two analog comparators
// assumes raw comparator outputs are asynchronous; timer overflow pulses are one clk wide
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module cmpdb_top
(
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [7:0]                             reg_addr,
    input  wire logic [7:0]                             reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic      [7:0]                             reg_rdata,
    input  wire logic [cmpdb_pkg::NUM_CMP-1:0]          cmp_out_raw,
    input  wire logic [2:0]                             tmr_ovf,
    output logic                                        irq,
    output logic                                        cmp_irq_req,
    output logic      [cmpdb_pkg::NUM_CMP-1:0]          input_connect,
    output logic      [cmpdb_pkg::NUM_CMP-1:0][1:0]     positive_channel,
    output logic      [cmpdb_pkg::NUM_PINS-1:0]         pin_dig_in_dis
);

    cmpdb_pkg::cmpdb_state_t q;
    cmpdb_pkg::cmpdb_state_t n;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cmpdb_pkg::cmpdb_mode_t m;
        logic       en;
        logic       raw;
        logic       stb;
        logic       edge_ev;
        logic       relevant;
        logic       hit;
        logic [2:0] need;
        logic [1:0] tsel;
        n = q;
        m = '0;
        en = 1'b0;
        raw = 1'b0;
        edge_ev = 1'b0;
        relevant = 1'b0;
        hit = 1'b0;
        // first stage feeds only the second
        n.sy1 = cmp_out_raw;
        n.sy2 = q.sy1;
        tsel = q.compare_sample_clock_select - 2'h1;
        // sampling strobe: every clock or a chosen timer overflow
        stb = (q.compare_sample_clock_select == cmpdb_pkg::SEL_SYSCLK) ? 1'b1 : tmr_ovf[tsel];
        need = (q.compare_sample_clock_select == cmpdb_pkg::SEL_SYSCLK) ? 3'h1 : cmpdb_pkg::STABLE_SAMPLES;

        if (reg_wr && reg_addr == cmpdb_pkg::OFS_CFG)
        begin
            n.compare_sample_clock_select = reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == cmpdb_pkg::OFS_IE)
        begin
            n.ie = reg_wdata;
        end
        if (reg_wr && reg_addr == cmpdb_pkg::OFS_IMASK)
        begin
            n.imask = reg_wdata[cmpdb_pkg::NUM_CMP-1:0];
        end
        if (reg_rd && reg_addr == cmpdb_pkg::OFS_ISTS)
        begin
            n.ists = '0;
        end

        // one filter per comparator, all on the shared debounce timer
        for (int i = 0; i < cmpdb_pkg::NUM_CMP; i++)
        begin
            // a written flag value stands, hardware sets win below
            if (reg_wr && reg_addr == cmpdb_pkg::CMP_OFS[i])
            begin
                n.cmp[i].ctrl = reg_wdata;
            end
            m = cmpdb_pkg::cmpdb_decode(q.cmp[i].ctrl[2:0]);
            en = q.cmp[i].ctrl[cmpdb_pkg::EN_BIT];
            raw = en & q.sy2[i];
            edge_ev = 1'b0;
            hit = 1'b0;
            if (!en)
            begin
                // disabled: output held low, no event can be recorded
                n.cmp[i].smp = 1'b0;
                n.cmp[i].acc = 1'b0;
                n.cmp[i].cnt = 3'h0;
                n.cmp[i].db = cmpdb_pkg::CMPDB_DB_IDLE;
                n.cmp[i].dbcnt = 2'h0;
            end
            else
            begin
                if (stb)
                begin
                    n.cmp[i].smp = raw;
                    if (raw == q.cmp[i].acc)
                    begin
                        n.cmp[i].cnt = 3'h0;
                    end
                    else if (q.cmp[i].cnt + 3'h1 >= need)
                    begin
                        n.cmp[i].acc = raw;
                        n.cmp[i].cnt = 3'h0;
                        edge_ev = 1'b1;
                    end
                    else
                    begin
                        n.cmp[i].cnt = q.cmp[i].cnt + 3'h1;
                    end
                    if (m.lvl)
                    begin
                        hit = (raw == m.pol);
                    end
                end
                relevant = edge_ev & ((raw & m.rise) | (!raw & m.fall));
                if (!m.db)
                begin
                    hit = hit | relevant;
                end
                else
                begin
                    unique case (q.cmp[i].db)
                        cmpdb_pkg::CMPDB_DB_IDLE:
                        begin
                            if (relevant)
                            begin
                                n.cmp[i].db = cmpdb_pkg::CMPDB_DB_WAIT;
                                n.cmp[i].dbcnt = 2'h0;
                                n.cmp[i].expv = raw;
                            end
                        end
                        cmpdb_pkg::CMPDB_DB_WAIT:
                        begin
                            // the overflow that sampled the edge is not counted
                            if (tmr_ovf[cmpdb_pkg::DB_TIMER])
                            begin
                                if (q.cmp[i].dbcnt == cmpdb_pkg::DB_OVF - 2'h1)
                                begin
                                    n.cmp[i].db = cmpdb_pkg::CMPDB_DB_IDLE;
                                    n.cmp[i].dbcnt = 2'h0;
                                    hit = (n.cmp[i].acc == q.cmp[i].expv);
                                end
                                else
                                begin
                                    n.cmp[i].dbcnt = q.cmp[i].dbcnt + 2'h1;
                                end
                            end
                        end
                        default:
                        begin
                            n.cmp[i].db = cmpdb_pkg::CMPDB_DB_IDLE;
                        end
                    endcase
                end
            end
            if (hit && !q.cmp[i].ctrl[cmpdb_pkg::FLAG_BIT])
            begin
                n.ists[i] = 1'b1;
            end
            if (hit)
            begin
                n.cmp[i].ctrl[cmpdb_pkg::FLAG_BIT] = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        n.irq = |(n.ists & n.imask);
        n.req = 1'b0;
        n.dig_dis = '0;
        for (int i = 0; i < cmpdb_pkg::NUM_CMP; i++)
        begin
            n.req = n.req | (n.ie[cmpdb_pkg::IE_CMP_BIT] & n.cmp[i].ctrl[cmpdb_pkg::FLAG_BIT]);
            n.con[i] = n.cmp[i].ctrl[cmpdb_pkg::CON_BIT];
            n.chan[i] = n.cmp[i].ctrl[cmpdb_pkg::CHAN_LSB +: 2];
            // only the selected positive channel pin is treated as in analog use
            if (n.cmp[i].ctrl[cmpdb_pkg::EN_BIT])
            begin
                n.dig_dis[n.chan[i]] = 1'b1;
            end
        end

        n.rdata = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                cmpdb_pkg::OFS_CMP_A: n.rdata = q.cmp[0].ctrl;
                cmpdb_pkg::OFS_CMP_B: n.rdata = q.cmp[1].ctrl;
                cmpdb_pkg::OFS_CFG:   n.rdata = {q.sy2, 4'h0, q.compare_sample_clock_select};
                cmpdb_pkg::OFS_IE:    n.rdata = q.ie;
                cmpdb_pkg::OFS_ISTS:  n.rdata = {6'h00, q.ists};
                cmpdb_pkg::OFS_IMASK: n.rdata = {6'h00, q.imask};
                default:              n.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            for (int i = 0; i < cmpdb_pkg::NUM_CMP; i++)
            begin
                q.cmp[i].ctrl <= cmpdb_pkg::CMP_RST[i];
                q.cmp[i].db <= cmpdb_pkg::CMPDB_DB_IDLE;
            end
        end
        else
        begin
            q <= n;
        end
    end

    assign reg_rdata        = q.rdata;
    assign irq              = q.irq;
    assign cmp_irq_req      = q.req;
    assign input_connect    = q.con;
    assign positive_channel = q.chan;
    assign pin_dig_in_dis   = q.dig_dis;

    ////////////////////////////////////////////////////////////////////////
    // checks on comparator A; comparator B shares the same code
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic       a_en;
    logic       a_flag;
    logic       a_wr;
    logic       a_last;
    logic       a_dbm;
    assign a_en   = q.cmp[0].ctrl[cmpdb_pkg::EN_BIT];
    assign a_flag = q.cmp[0].ctrl[cmpdb_pkg::FLAG_BIT];
    assign a_wr   = reg_wr && reg_addr == cmpdb_pkg::OFS_CMP_A;
    assign a_last = a_en && !a_wr && q.cmp[0].ctrl[2:0] inside {3'h2, 3'h3, 3'h6}
                    && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT && q.cmp[0].dbcnt == 2'h1
                    && tmr_ovf[1] && !a_flag;
    assign a_dbm  = q.cmp[0].ctrl[2:0] inside {3'h2, 3'h3, 3'h6};

    chk_flag_needs_en: assert property ($rose(a_flag) && !$past(a_wr) |-> $past(a_en))
        else $error("event flag set while comparator disabled");
    chk_sample_forced_low: assert property (!a_en |=> !q.cmp[0].smp)
        else $error("sample not forced low while disabled");
    chk_every_clock_sample: assert property (a_en && !a_wr && q.compare_sample_clock_select == 2'h0 |=> q.cmp[0].smp == $past(q.sy2[0]))
        else $error("sample missed a system clock");
    chk_wait_holds: assert property (a_en && !a_wr && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT && !tmr_ovf[1]
                                     |=> q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT)
        else $error("debounce wait left without overflow");
    chk_resample_match: assert property (a_last |=> a_flag == (q.cmp[0].acc == $past(q.cmp[0].expv)))
        else $error("debounce resample result wrong");
    chk_four_samples: assert property (a_en && $past(a_en) && $changed(q.cmp[0].acc) && $past(q.compare_sample_clock_select) != 2'h0
                                       |-> $past(q.cmp[0].cnt) == 3'h3)
        else $error("edge accepted without four samples");
    chk_ie_gate: assert property (!q.ie[6] && !(reg_wr && reg_addr == cmpdb_pkg::OFS_IE) |=> !cmp_irq_req)
        else $error("request passed with enable bit clear");
    chk_connect_bit: assert property (a_wr |=> input_connect[0] == $past(reg_wdata[5]))
        else $error("connect output does not follow bit");
    chk_dig_disable: assert property (a_en && !a_wr |=> pin_dig_in_dis[$past(q.cmp[0].ctrl[7:6])])
        else $error("digital input left on for comparator pin");
    chk_flag_sticky: assert property (a_flag && !a_wr |=> a_flag)
        else $error("event flag cleared by hardware");
    chk_irq_level: assert property (irq == |(q.ists & q.imask))
        else $error("interrupt output disagrees with status and mask");

    ////////////////////////////////////////////////////////////////////////
    // register port, status and per-mode checks
    chk_rdata_idle: assert property (!reg_rd
                                     |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_rdata_ctrl_a: assert property (reg_rd && reg_addr == cmpdb_pkg::OFS_CMP_A
                                       |=> reg_rdata == $past(q.cmp[0].ctrl))
        else $error("control read returned wrong value");
    chk_status_clear: assert property (reg_rd && reg_addr == cmpdb_pkg::OFS_ISTS && !a_en
                                       |=> !q.ists[0])
        else $error("status bit not cleared by read");
    chk_status_sticky: assert property (q.ists[0] && !(reg_rd && reg_addr == cmpdb_pkg::OFS_ISTS)
                                        |=> q.ists[0])
        else $error("status bit lost without a read");
    chk_flag_sets_status: assert property ($rose(a_flag) && !$past(a_wr)
                                           |-> q.ists[0])
        else $error("flag set without status bit");
    chk_disabled_no_wait: assert property (!a_en
                                           |=> q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE)
        else $error("debounce wait kept while disabled");
    chk_disabled_no_flag: assert property (!a_en && !a_wr && !a_flag
                                           |=> !a_flag)
        else $error("event recorded while disabled");
    chk_db_no_direct: assert property (a_en && !a_wr && !a_flag && a_dbm && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE
                                       |=> !a_flag)
        else $error("debounced flag set without wait");
    chk_db_wait_no_flag: assert property (a_en && !a_wr && !a_flag && a_dbm && !tmr_ovf[1]
                                          |=> !a_flag)
        else $error("debounced flag set between overflows");
    chk_wait_exit: assert property (a_en && a_dbm && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT && q.cmp[0].dbcnt == 2'h1
                                    && tmr_ovf[1] |=> q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE)
        else $error("debounce wait not left at second overflow");
    chk_db_count_step: assert property (a_en && a_dbm && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT
                                        && q.cmp[0].dbcnt == 2'h0 && tmr_ovf[1] |=> q.cmp[0].dbcnt == 2'h1)
        else $error("first overflow of the wait not counted");
    chk_db_enter: assert property (a_en && a_dbm && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE
                                   ##1 q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT |-> $changed(q.cmp[0].acc))
        else $error("debounce wait entered without an edge event");
    chk_db_expect: assert property (a_en && a_dbm && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE
                                    ##1 q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT |-> q.cmp[0].expv == q.cmp[0].acc)
        else $error("expected value differs from accepted edge");
    chk_mode_rise_only: assert property (a_en && q.cmp[0].ctrl[2:0] == 3'h3 && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE
                                         ##1 q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT |-> q.cmp[0].acc)
        else $error("positive debounce started on a falling edge");
    chk_mode_fall_only: assert property (a_en && q.cmp[0].ctrl[2:0] == 3'h6 && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_IDLE
                                         ##1 q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT |-> !q.cmp[0].acc)
        else $error("negative debounce started on a rising edge");
    chk_plain_edge: assert property (a_en && !a_wr && !a_flag && q.cmp[0].ctrl[2:0] == 3'h1
                                     ##1 a_flag |-> q.cmp[0].acc && !$past(q.cmp[0].acc))
        else $error("positive edge flag without a rising edge");
    chk_level_low: assert property (a_en && !a_wr && q.compare_sample_clock_select == 2'h0 && q.cmp[0].ctrl[2:0] == 3'h0 && !q.sy2[0]
                                    |=> a_flag)
        else $error("low level did not set the flag");
    chk_timer_strobe_only: assert property (a_en && q.compare_sample_clock_select == 2'h1 && !tmr_ovf[0]
                                            |=> $stable(q.cmp[0].smp))
        else $error("sample taken without its overflow");
    chk_timer_sample_take: assert property (a_en && q.compare_sample_clock_select == 2'h1 && tmr_ovf[0]
                                            |=> q.cmp[0].smp == $past(q.sy2[0]))
        else $error("sample missed its overflow");
    chk_cfg_write: assert property (reg_wr && reg_addr == cmpdb_pkg::OFS_CFG
                                    |=> q.compare_sample_clock_select == $past(reg_wdata[1:0]))
        else $error("sampling select not written");
    chk_four_no_early: assert property (a_en && !a_wr && q.compare_sample_clock_select != 2'h0 && q.cmp[0].cnt < 3'h3
                                        |=> $stable(q.cmp[0].acc))
        else $error("edge accepted before four samples");
    chk_req_flag: assert property (q.ie[6] && a_flag && !a_wr && !(reg_wr && reg_addr == cmpdb_pkg::OFS_IE)
                                   |=> cmp_irq_req)
        else $error("request missing with flag and enable set");
    chk_b_disabled: assert property (!q.cmp[1].ctrl[cmpdb_pkg::EN_BIT]
                                     |=> !q.cmp[1].smp && q.cmp[1].db == cmpdb_pkg::CMPDB_DB_IDLE)
        else $error("second filter active while disabled");
    chk_b_no_flag: assert property (!q.cmp[1].ctrl[cmpdb_pkg::EN_BIT] && !q.cmp[1].ctrl[cmpdb_pkg::FLAG_BIT]
                                    && !(reg_wr && reg_addr == cmpdb_pkg::OFS_CMP_B) |=> !q.cmp[1].ctrl[cmpdb_pkg::FLAG_BIT])
        else $error("second flag set while disabled");

    cov_db_fire: cover property (a_last && q.cmp[0].acc == q.cmp[0].expv);
    cov_db_drop: cover property (a_last && q.cmp[0].acc != q.cmp[0].expv);
    cov_four_accept: cover property (q.compare_sample_clock_select != 2'h0 && a_en ##1 $changed(q.cmp[0].acc));
    cov_irq: cover property ($rose(irq));
    cov_db_wait: cover property (a_en && q.cmp[0].ctrl[2:0] == 3'h3 && q.cmp[0].db == cmpdb_pkg::CMPDB_DB_WAIT);

endmodule

// >>> cmpdb_far_side.sv
// far-side model: analog comparator outputs and three free-running timer overflows
// assumes the bench sets the analog decision levels; pulses are one clk wide
`timescale 1ns/100ps
module cmpdb_far_side
#(
    parameter int P0 = 10,
    parameter int P1 = 16,
    parameter int P2 = 12
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] cmp_level,
    output logic      [1:0] cmp_out_raw,
    output logic      [2:0] tmr_ovf
);
    localparam int PER [3] = '{P0, P1, P2};
    int cnt [3];

    // small skew so the raw output never moves on a clock edge
    assign #3 cmp_out_raw = cmp_level;

    ////////////////////////////////////////////////////////////////
    // timers never stop or restart, so an edge lands anywhere in a period
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
                cnt[i] <= 0;
            tmr_ovf <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                cnt[i] <= (cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
                tmr_ovf[i] <= (cnt[i] == PER[i] - 1);
            end
        end
    end
endmodule

// >>> test_comparator_interrupt_debounce.sv
// self-checking bench for the comparator event and debounce logic
// assumes the far-side model drives raw outputs and timer overflows
`timescale 1ns/100ps
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module test_comparator_interrupt_debounce;
    localparam int P0 = 10;
    localparam int P1 = 16;
    localparam int P2 = 12;
    logic            clk, rst, reg_wr, reg_rd, irq, cmp_irq_req;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata;
    logic [1:0]      cmp_level, cmp_out_raw, input_connect;
    logic [2:0]      tmr_ovf;
    logic [1:0][1:0] positive_channel;
    logic [3:0]      pin_dig_in_dis;
    int              fails, samples_checked, n;

    cmpdb_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_out_raw(cmp_out_raw), .tmr_ovf(tmr_ovf), .irq(irq),
        .cmp_irq_req(cmp_irq_req), .input_connect(input_connect), .positive_channel(positive_channel),
        .pin_dig_in_dis(pin_dig_in_dis));
    cmpdb_far_side #(.P0(P0), .P1(P1), .P2(P2)) u_far (.clk(clk), .rst(rst), .cmp_level(cmp_level),
        .cmp_out_raw(cmp_out_raw), .tmr_ovf(tmr_ovf));

    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        `chk(d, e)
    endtask

    // drives one comparator transition, then counts cycles until irq rises
    task automatic edge_to_irq(input int c, input logic v, input int lo, input int hi);
        @(posedge clk);
        cmp_level[c] <= v;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 400)
        begin
            fails++;
            tally_and_finish();
        end
        `chk(n >= lo && n <= hi, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(8'ha3, 8'h00);
        rdchk(8'hab, 8'hc0);
        rdchk(8'hff, 8'h00);
        `chk(positive_channel[1], 2'h3)
        `chk(irq, 1'b0)
    endtask

    task automatic t_plain_edge();
        wr(8'hb1, 8'h03);
        wr(8'ha8, 8'h40);
        wr(8'ha3, 8'h29);
        repeat (2) @(posedge clk);
        `chk(input_connect, 2'h1)
        `chk(pin_dig_in_dis, 4'h1)
        edge_to_irq(0, 1'b1, 3, 6);
        `chk(cmp_irq_req, 1'b1)
        rdchk(8'hb0, 8'h01);
        repeat (2) @(posedge clk);
        `chk(irq, 1'b0)
        cmp_level[0] <= 1'b0;
        repeat (10) @(posedge clk);
        rdchk(8'ha3, 8'h39);
        rdchk(8'hb0, 8'h00);
        wr(8'ha8, 8'h00);
        repeat (2) @(posedge clk);
        `chk(cmp_irq_req, 1'b0)
        wr(8'ha3, 8'h29);
        rdchk(8'ha3, 8'h29);
    endtask

    task automatic t_disable();
        wr(8'ha3, 8'h21);
        repeat (2) @(posedge clk);
        `chk(pin_dig_in_dis, 4'h0)
        cmp_level[0] <= 1'b1;
        repeat (8) @(posedge clk);
        cmp_level[0] <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(8'ha3, 8'h21);
        rdchk(8'hb0, 8'h00);
    endtask

    // debounced positive, negative and toggle codes; a short glitch first
    task automatic t_debounce();
        logic [2:0] md [3] = '{3'h3, 3'h6, 3'h2};
        logic       s;
        for (int i = 0; i < 3; i++)
        begin
            s = (md[i] == 3'h6);
            wr(8'ha3, 8'h20);
            cmp_level[0] <= s;
            repeat (6) @(posedge clk);
            wr(8'ha3, {5'h05, md[i]});
            repeat (6) @(posedge clk);
            cmp_level[0] <= !s;
            repeat (3) @(posedge clk);
            cmp_level[0] <= s;
            repeat (3 * P1) @(posedge clk);
            rdchk(8'hb0, 8'h00);
            edge_to_irq(0, !s, P1, 2 * P1 + 8);
            rdchk(8'hb0, 8'h01);
        end
    endtask

    task automatic t_cmp_b();
        wr(8'ha3, 8'h00);
        // channel left at its reset value while connecting
        wr(8'hab, 8'he9);
        repeat (2) @(posedge clk);
        `chk(input_connect, 2'h2)
        `chk(positive_channel[1], 2'h3)
        `chk(pin_dig_in_dis, 4'h8)
        edge_to_irq(1, 1'b1, 3, 6);
        rdchk(8'hb0, 8'h02);
        rdchk(8'hab, 8'hf9);
        wr(8'hab, 8'hc0);
    endtask

    // timer0 and timer2 as sampling clock, then timer1 sampling with debounce
    task automatic t_timer_sample();
        logic [7:0] sel [3] = '{8'h01, 8'h03, 8'h02};
        int         p [3] = '{P0, P2, P1};
        for (int i = 0; i < 3; i++)
        begin
            wr(8'ha3, 8'h20);
            cmp_level[0] <= 1'b0;
            wr(8'ha1, sel[i]);
            wr(8'ha3, i == 2 ? 8'h2b : 8'h29);
            repeat (6 * p[i]) @(posedge clk);
            if (i < 2)
                edge_to_irq(0, 1'b1, 3 * p[i], 4 * p[i] + 8);
            else
                edge_to_irq(0, 1'b1, 5 * P1, 6 * P1 + 8);
            rdchk(8'hb0, 8'h01);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmp_level = 2'h0;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_plain_edge();
        t_disable();
        t_debounce();
        t_cmp_b();
        t_timer_sample();
        tally_and_finish();
    end
endmodule
